// File: core/ssp_pkg.sv
// Shared constants and types of the serial port.
package ssp_pkg;

    // Frame and buffer geometry.
    localparam int SSP_DATA_W     = 8;
    localparam int SSP_FIFO_DEPTH = 8;

    // Timing: bit clock half period when the port makes the clock.
    localparam int SSP_CLK_PERIOD_NS = 25;
    localparam int SSP_SCK_HALF_NS   = 100;
    localparam int SSP_SCK_HALF_CYC  = (SSP_SCK_HALF_NS + SSP_CLK_PERIOD_NS - 1)
                                       / SSP_CLK_PERIOD_NS;
    localparam int SSP_HALF_W        = 3;

    // Reset values.
    localparam logic [7:0] SSP_CRC_INIT = 8'h00;
    localparam logic [7:0] SSP_DATA_RST = 8'h00;

    // Audio framing formats.
    localparam logic [1:0] SSP_FMT_STD = 2'h0;
    localparam logic [1:0] SSP_FMT_MSB = 2'h1;
    localparam logic [1:0] SSP_FMT_LSB = 2'h2;

    typedef enum logic [1:0] {
        SSP_ST_IDLE  = 2'b00,
        SSP_ST_ARMED = 2'b01,
        SSP_ST_FRAME = 2'b10
    } ssp_state_type;

endpackage

// File: core/ssp_serial_port.sv
// Serial port engine (SPI master or slave, audio slave) with its transmit FIFO.
`timescale 1ns/1ps

module ssp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Fill side.
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    // Drain side.
    output logic      [WIDTH-1:0] out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;
    assign in_ready_out  = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid_out = cnt_reg != '0;
    assign out_data_out  = mem_reg[rd_reg];

    always_comb begin
        wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next = (AW+1)'(cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage has no reset; nothing reads an entry before it is written.
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data_in;
        end
    end
endmodule // ssp_fifo

module ssp_serial_port (
    // Clock and reset.
    input  wire logic                           clk_in,
    input  wire logic                           rst_n_in,
    // Configuration and control.
    input  wire logic                           port_enable_in,
    input  wire logic                           master_mode_in,
    input  wire logic                           i2s_mode_in,
    input  wire logic [1:0]                     i2s_format_in,
    input  wire logic                           checksum_en_in,
    input  wire logic [7:0]                     checksum_poly_in,
    input  wire logic                           checksum_next_ctrl_in,
    input  wire logic                           checksum_error_clr_in,
    input  wire logic                           bidir_mode_in,
    input  wire logic                           bidir_tx_in,
    // Transmit stream.
    input  wire logic [ssp_pkg::SSP_DATA_W-1:0] tx_data_in,
    input  wire logic                           tx_valid_in,
    output logic                                tx_ready_out,
    // Receive stream and status.
    output logic      [ssp_pkg::SSP_DATA_W-1:0] rx_data_out,
    output logic                                rx_not_empty_event_out,
    output logic                                tx_empty_event_out,
    output logic                                busy_flag_out,
    output logic                                checksum_error_flag_out,
    // Serial pins.
    input  wire logic                           sck_in,
    output logic                                sck_out,
    output logic                                sck_oe_out,
    input  wire logic                           sdi_in,
    output logic                                sdo_out,
    output logic                                sdo_oe_out,
    input  wire logic                           ws_in,
    input  wire logic                           slave_select_line_in,
    output logic                                slave_select_line_out
);
    import ssp_pkg::*;

    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic b,
                                            input logic [7:0] poly);
        crc_step = {crc[6:0], 1'b0} ^ ((crc[7] ^ b) ? poly : 8'h00);
    endfunction

    // Synchronisers: stage 1 feeds only stage 2; stage 3 is for edges.
    logic [2:0] sck_s, ws_s, ss_s, sdi_s;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_s <= 3'h0;
            ws_s  <= 3'h0;
            ss_s  <= 3'h7;
            sdi_s <= 3'h0;
        end else begin
            sck_s <= {sck_s[1:0], sck_in};
            ws_s  <= {ws_s[1:0], ws_in};
            ss_s  <= {ss_s[1:0], slave_select_line_in};
            sdi_s <= {sdi_s[1:0], sdi_in};
        end
    end

    ssp_state_type              state_reg, state_next;
    logic [SSP_HALF_W-1:0]      half_reg, half_next;
    logic [7:0]                 tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next;
    logic [7:0]                 tx_crc_reg, tx_crc_next, rx_crc_reg, rx_crc_next;
    logic [7:0]                 rx_data_reg, rx_data_next;
    logic [2:0]                 tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
    logic                       sck_reg, sck_next, ss_reg, ss_next;
    logic                       end_reg, end_next, is_crc_reg, is_crc_next;
    logic                       pend_reg, pend_next, err_reg, err_next;
    logic                       txe_reg, txe_next, rx_not_empty_event_reg, rx_not_empty_event_next;
    logic                       busy_reg, busy_next, sckoe_reg, sckoe_next;
    logic                       sdooe_reg, sdooe_next;
    logic                       crc_bit_reg, crc_bit_next, fbp_reg, fbp_next;
    logic                       pop, f_valid, expire, samp, shft, fb_rise;
    logic                       start_lvl, start, rx_bit, can_crc;
    logic [7:0]                 f_data;

    ssp_fifo #(
        .WIDTH (SSP_DATA_W),
        .DEPTH (SSP_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .in_data_in    (tx_data_in),
        .in_valid_in   (tx_valid_in),
        .in_ready_out  (tx_ready_out),
        .out_data_out  (f_data),
        .out_valid_out (f_valid),
        .out_ready_in  (pop)
    );

    // Justified formats start on high, standard on low.
    assign start_lvl = (i2s_format_in != SSP_FMT_STD);
    assign start     = i2s_mode_in ? (ws_s[1] == start_lvl) : ~ss_s[1];
    assign expire    = half_reg == SSP_HALF_W'(SSP_SCK_HALF_CYC - 1);
    // The master's transmit checksum follows the fed-back clock; the bit stays valid for a
    // whole half period, so up to two cycles of pad delay are harmless.
    assign fb_rise   = sck_s[1] & ~sck_s[2];
    assign samp      = master_mode_in ? (expire & ~sck_reg) : (sck_s[1] & ~sck_s[2]);
    assign shft      = master_mode_in ? (expire & sck_reg) : (~sck_s[1] & sck_s[2]);
    assign rx_bit    = sdi_s[1];
    assign can_crc   = checksum_en_in & pend_reg & ~is_crc_reg;

    always_comb begin
        state_next   = state_reg;
        half_next    = half_reg;
        tx_sh_next   = tx_sh_reg;
        rx_sh_next   = rx_sh_reg;
        tx_crc_next  = tx_crc_reg;
        rx_crc_next  = rx_crc_reg;
        rx_data_next = rx_data_reg;
        tx_cnt_next  = tx_cnt_reg;
        rx_cnt_next  = rx_cnt_reg;
        sck_next     = sck_reg;
        ss_next      = ss_reg;
        end_next     = end_reg;
        is_crc_next  = is_crc_reg;
        pend_next    = pend_reg;
        err_next     = err_reg & ~checksum_error_clr_in;
        txe_next     = 1'b0;
        rx_not_empty_event_next    = 1'b0;
        pop          = 1'b0;
        crc_bit_next = crc_bit_reg;
        fbp_next     = fbp_reg;
        if (checksum_next_ctrl_in) begin
            pend_next = 1'b1;
        end
        // The sent bit is held until its fed-back edge, which lands after
        // the shift edge once the loop delay reaches two cycles.
        if (fb_rise & master_mode_in & fbp_reg) begin
            tx_crc_next = crc_step(tx_crc_reg, crc_bit_reg, checksum_poly_in);
            fbp_next    = 1'b0;
        end
        case (state_reg)
            SSP_ST_IDLE: begin
                sck_next = 1'b0;
                ss_next  = 1'b1;
                if (port_enable_in) begin
                    pop         = f_valid;
                    tx_sh_next  = f_valid ? f_data : SSP_DATA_RST;
                    tx_cnt_next = 3'h0;
                    rx_cnt_next = 3'h0;
                    end_next    = 1'b0;
                    is_crc_next = 1'b0;
                    half_next   = '0;
                    if (!master_mode_in) begin
                        state_next = SSP_ST_ARMED;
                    end else if (f_valid) begin
                        state_next = SSP_ST_FRAME;
                        ss_next    = 1'b0;
                    end
                end
            end
            SSP_ST_ARMED: begin
                if (!port_enable_in) begin
                    state_next = SSP_ST_IDLE;
                end else if (start) begin
                    state_next = SSP_ST_FRAME;
                end
            end
            SSP_ST_FRAME: begin
                if (master_mode_in) begin
                    half_next = expire ? '0 : SSP_HALF_W'(half_reg + 1'b1);
                    sck_next  = expire ? ~sck_reg : sck_reg;
                end
                if (samp & ~end_reg) begin
                    if (master_mode_in && !is_crc_reg) begin
                        crc_bit_next = tx_sh_reg[7];
                        fbp_next     = 1'b1;
                    end
                    rx_sh_next  = {rx_sh_reg[6:0], rx_bit};
                    rx_cnt_next = 3'(rx_cnt_reg + 1'b1);
                    if (!is_crc_reg) begin
                        rx_crc_next = crc_step(rx_crc_reg, rx_bit, checksum_poly_in);
                    end
                    if (!master_mode_in && !is_crc_reg) begin
                        tx_crc_next = crc_step(tx_crc_reg, tx_sh_reg[7], checksum_poly_in);
                    end
                    if (rx_cnt_reg == 3'h7) begin
                        // Last bit lands in the stored word and the check.
                        rx_data_next = {rx_sh_reg[6:0], rx_bit};
                        rx_not_empty_event_next    = 1'b1;
                        end_next     = 1'b1;
                        if (is_crc_reg && ({rx_sh_reg[6:0], rx_bit} != rx_crc_reg)) begin
                            err_next = 1'b1;
                        end
                    end
                end
                if (shft && end_reg) begin
                    end_next    = 1'b0;
                    tx_cnt_next = 3'h0;
                    rx_cnt_next = 3'h0;
                    if (is_crc_reg) begin
                        tx_crc_next = SSP_CRC_INIT;
                        rx_crc_next = SSP_CRC_INIT;
                        fbp_next    = 1'b0;
                    end
                    is_crc_next = 1'b0;
                    if (port_enable_in && f_valid && !is_crc_reg) begin
                        pop        = 1'b1;
                        tx_sh_next = f_data;
                    end else if (port_enable_in && can_crc) begin
                        tx_sh_next  = fbp_reg ? crc_step(tx_crc_reg, crc_bit_reg,
                                                         checksum_poly_in)
                                              : tx_crc_reg;
                        fbp_next    = 1'b0;
                        is_crc_next = 1'b1;
                        pend_next   = checksum_next_ctrl_in;
                    end else if (port_enable_in && !master_mode_in) begin
                        tx_sh_next = SSP_DATA_RST;
                    end else begin
                        state_next = SSP_ST_IDLE;
                        ss_next    = 1'b1;
                    end
                end else if (shft) begin
                    tx_sh_next  = {tx_sh_reg[6:0], 1'b0};
                    tx_cnt_next = 3'(tx_cnt_reg + 1'b1);
                    txe_next    = (tx_cnt_reg == 3'h0) & ~is_crc_reg;
                end
                // Losing slave select aborts a slave frame; word select is
                // deliberately ignored once an audio frame is running.
                if (!master_mode_in && !i2s_mode_in && ss_s[1]) begin
                    state_next = port_enable_in ? SSP_ST_ARMED : SSP_ST_IDLE;
                end
            end
            default: begin
                state_next = SSP_ST_IDLE;
            end
        endcase
        if (!checksum_en_in) begin
            tx_crc_next = SSP_CRC_INIT;
            rx_crc_next = SSP_CRC_INIT;
            pend_next   = 1'b0;
        end
        if (checksum_next_ctrl_in && checksum_en_in) begin
            pend_next = pend_next | 1'b1;
        end
        busy_next  = state_next == SSP_ST_FRAME;
        sckoe_next = master_mode_in & port_enable_in;
        // In two-way mode the data pin is driven only while software says so.
        sdooe_next = (state_next != SSP_ST_IDLE) & (~bidir_mode_in | bidir_tx_in);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg   <= SSP_ST_IDLE;
            half_reg    <= '0;
            tx_sh_reg   <= SSP_DATA_RST;
            rx_sh_reg   <= SSP_DATA_RST;
            tx_crc_reg  <= SSP_CRC_INIT;
            rx_crc_reg  <= SSP_CRC_INIT;
            rx_data_reg <= SSP_DATA_RST;
            tx_cnt_reg  <= 3'h0;
            rx_cnt_reg  <= 3'h0;
            sck_reg     <= 1'b0;
            ss_reg      <= 1'b1;
            end_reg     <= 1'b0;
            is_crc_reg  <= 1'b0;
            pend_reg    <= 1'b0;
            err_reg     <= 1'b0;
            txe_reg     <= 1'b0;
            rx_not_empty_event_reg    <= 1'b0;
            busy_reg    <= 1'b0;
            sckoe_reg   <= 1'b0;
            sdooe_reg   <= 1'b0;
            crc_bit_reg <= 1'b0;
            fbp_reg     <= 1'b0;
        end else begin
            state_reg   <= state_next;
            half_reg    <= half_next;
            tx_sh_reg   <= tx_sh_next;
            rx_sh_reg   <= rx_sh_next;
            tx_crc_reg  <= tx_crc_next;
            rx_crc_reg  <= rx_crc_next;
            rx_data_reg <= rx_data_next;
            tx_cnt_reg  <= tx_cnt_next;
            rx_cnt_reg  <= rx_cnt_next;
            sck_reg     <= sck_next;
            ss_reg      <= ss_next;
            end_reg     <= end_next;
            is_crc_reg  <= is_crc_next;
            pend_reg    <= pend_next;
            err_reg     <= err_next;
            txe_reg     <= txe_next;
            rx_not_empty_event_reg    <= rx_not_empty_event_next;
            busy_reg    <= busy_next;
            sckoe_reg   <= sckoe_next;
            sdooe_reg   <= sdooe_next;
            crc_bit_reg <= crc_bit_next;
            fbp_reg     <= fbp_next;
        end
    end

    assign rx_data_out             = rx_data_reg;
    assign rx_not_empty_event_out  = rx_not_empty_event_reg;
    assign tx_empty_event_out      = txe_reg;
    assign busy_flag_out           = busy_reg;
    assign checksum_error_flag_out = err_reg;
    assign sck_out                 = sck_reg;
    assign sck_oe_out              = sckoe_reg;
    assign sdo_out                 = tx_sh_reg[7];
    assign sdo_oe_out              = sdooe_reg;
    assign slave_select_line_out   = ss_reg;
endmodule // ssp_serial_port

// File: dv/ssp_peer_model.sv
// Far-side model: SPI slave for master runs, audio master for slave runs.
`timescale 1ns/1ps
module ssp_peer_model (
    // Device pins seen by the peer.
    input  wire logic sck_dev_in,
    input  wire logic ss_n_in,
    input  wire logic sdo_in,
    input  wire logic audio_in,
    // Lines driven by the peer.
    output logic      sck_out,
    output logic      sdi_out,
    output logic      ws_out
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    logic [7:0] sh_tx = 8'h00;
    logic [7:0] sh_rx = 8'h00;
    int         cnt = 0;
    initial begin
        sck_out = 1'b0;
        sdi_out = 1'b0;
        ws_out = 1'b0;
    end
    // A released line shows the inverse so that a stale bit never passes.
    always @(posedge ss_n_in) if (!audio_in) begin
        sdi_out = ~sdi_out;
    end
    always @(negedge ss_n_in) if (!audio_in) begin
        sh_tx = tx_q.size() ? tx_q[0] : 8'h00;
        sdi_out = sh_tx[7];
        cnt = 0;
    end
    always @(posedge sck_dev_in) if (!audio_in && !ss_n_in) begin
        if (cnt == 0 && tx_q.size() > 0)
            void'(tx_q.pop_front());
        sh_rx = {sh_rx[6:0], sdo_in};
        cnt = (cnt + 1) % 8;
        if (cnt == 0)
            rx_q.push_back(sh_rx);
    end
    always @(negedge sck_dev_in) if (!audio_in && !ss_n_in) begin
        sh_tx = (cnt == 0) ? (tx_q.size() ? tx_q[0] : 8'h00) : {sh_tx[6:0], 1'b0};
        sdi_out = sh_tx[7];
    end
    // Bit clock runs only inside words; word select moves only while it is low.
    task automatic audio_word(input logic [7:0] d, input logic ws_lvl);
        logic [7:0] got;
        ws_out = ws_lvl;
        for (int i = 7; i >= 0; i--) begin
            sdi_out = d[i];
            #100 sck_out = 1'b1;
            got = {got[6:0], sdo_in};
            #100 sck_out = 1'b0;
        end
        rx_q.push_back(got);
        sdi_out = ~sdi_out;
    endtask
endmodule // ssp_peer_model

// File: dv/ssp_serial_port_checker.sv
// Port-level assertions for the serial port.
`timescale 1ns/1ps
module ssp_serial_port_checker (
    // Clock, reset and controls.
    input wire logic                           clk_in,
    input wire logic                           rst_n_in,
    input wire logic                           port_enable_in,
    input wire logic                           master_mode_in,
    input wire logic                           i2s_mode_in,
    input wire logic                           checksum_error_clr_in,
    // Observed outputs.
    input wire logic [ssp_pkg::SSP_DATA_W-1:0] rx_data_out,
    input wire logic                           rx_not_empty_event_out,
    input wire logic                           tx_empty_event_out,
    input wire logic                           busy_flag_out,
    input wire logic                           checksum_error_flag_out,
    input wire logic                           slave_select_line_out
);
    import ssp_pkg::*;
    wire spi_master = master_mode_in && !i2s_mode_in;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    AST_TXE_IN_FRAME: assert property (
        tx_empty_event_out |-> busy_flag_out ##1 !tx_empty_event_out)
        else $error("tx empty pulse outside a frame or too long");
    AST_TXE_TIMING: assert property (
        $rose(busy_flag_out) && spi_master |-> (!tx_empty_event_out) [*5] ##[1:8] tx_empty_event_out)
        else $error("tx empty pulse not at the second bit");
    AST_RX_NOT_EMPTY_EVENT_TIMING: assert property (
        $rose(busy_flag_out) && spi_master |-> ##[56:66] rx_not_empty_event_out)
        else $error("receive pulse missing at frame end");
    AST_RX_NOT_EMPTY_EVENT_PULSE: assert property (
        rx_not_empty_event_out |=> !rx_not_empty_event_out)
        else $error("receive pulse longer than one cycle");
    AST_RXDATA_HOLD: assert property (
        !rx_not_empty_event_out |-> $stable(rx_data_out))
        else $error("received data changed without a frame");
    AST_BUSY_DROPS: assert property (
        $fell(port_enable_in) && busy_flag_out && master_mode_in |-> ##[1:150] !busy_flag_out)
        else $error("busy stuck after disable");
    AST_SS_START: assert property (
        $rose(busy_flag_out) && spi_master |-> (!slave_select_line_out) [*2])
        else $error("select line not active at frame start");
    AST_CHECKSUM_ERROR_FLAG_STICKY: assert property (
        checksum_error_flag_out && !checksum_error_clr_in |=> checksum_error_flag_out)
        else $error("checksum error flag lost without clear");
endmodule // ssp_serial_port_checker

bind ssp_serial_port ssp_serial_port_checker CHK (
    .clk_in, .rst_n_in, .port_enable_in, .master_mode_in, .i2s_mode_in, .checksum_error_clr_in,
    .rx_data_out, .rx_not_empty_event_out, .tx_empty_event_out, .busy_flag_out,
    .checksum_error_flag_out, .slave_select_line_out);

// File: dv/ssp_serial_port_tb.sv
// Self-checking bench for the serial port and its far-side model.
`timescale 1ns/1ps
module ssp_serial_port_tb;
    import ssp_pkg::*;
    logic                  clk_in = 1'b0;
    logic                  rst_n_in = 1'b0;
    logic                  port_enable_in = 1'b0;
    logic                  master_mode_in = 1'b1;
    logic                  i2s_mode_in = 1'b0;
    logic [1:0]            i2s_format_in = SSP_FMT_STD;
    logic                  checksum_en_in = 1'b0;
    logic [7:0]            checksum_poly_in = 8'h07;
    logic                  checksum_next_ctrl_in = 1'b0;
    logic                  checksum_error_clr_in = 1'b0;
    logic                  bidir_mode_in = 1'b0;
    logic                  bidir_tx_in = 1'b0;
    logic                  slave_select_line_in = 1'b1;
    logic [SSP_DATA_W-1:0] tx_data_in = 8'h00;
    logic                  tx_valid_in = 1'b0;
    logic [1:0]            sck_dly = 2'h0;
    wire                   tx_ready_out, rx_not_empty_event_out, tx_empty_event_out;
    wire                   busy_flag_out, checksum_error_flag_out, sck_out, sdo_out;
    wire                   slave_select_line_out, peer_sck, peer_sdi, peer_ws;
    wire  [SSP_DATA_W-1:0] rx_data_out;
    wire                   sck_in = i2s_mode_in ? peer_sck : sck_dly[1];
    int                    bad_count = 0;
    int                    cmp_count = 0;
    int                    cycles = 0;
    int                    tx_pulses = 0;
    ssp_serial_port DUT (
        .clk_in, .rst_n_in, .port_enable_in, .master_mode_in, .i2s_mode_in, .i2s_format_in,
        .checksum_en_in, .checksum_poly_in, .checksum_next_ctrl_in, .checksum_error_clr_in,
        .bidir_mode_in, .bidir_tx_in, .tx_data_in, .tx_valid_in, .tx_ready_out, .rx_data_out,
        .rx_not_empty_event_out, .tx_empty_event_out, .busy_flag_out, .checksum_error_flag_out,
        .sck_in, .sck_out, .sck_oe_out(), .sdi_in(peer_sdi), .sdo_out, .sdo_oe_out(),
        .ws_in(peer_ws), .slave_select_line_in, .slave_select_line_out);
    ssp_peer_model PEER (
        .sck_dev_in(sck_out), .ss_n_in(slave_select_line_out), .sdo_in(sdo_out),
        .audio_in(i2s_mode_in), .sck_out(peer_sck), .sdi_out(peer_sdi), .ws_out(peer_ws));
    always #12.5 clk_in = ~clk_in;
    // Feedback clock lags the pin by two bus cycles, the worst the port must absorb.
    always @(posedge clk_in) begin
        sck_dly <= {sck_dly[0], sck_out};
        if (tx_empty_event_out === 1'b1)
            tx_pulses++;
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (bad_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] d[$]);
        logic [7:0] c;
        c = SSP_CRC_INIT;
        foreach (d[i])
            for (int b = 7; b >= 0; b--)
                c = (c[7] ^ d[i][b]) ? ({c[6:0], 1'b0} ^ checksum_poly_in) : {c[6:0], 1'b0};
        return c;
    endfunction
    task automatic do_reset();
        @(negedge clk_in);
        rst_n_in = 1'b0;
        port_enable_in = 1'b0;
        repeat (10) @(negedge clk_in);
        rst_n_in = 1'b1;
    endtask
    task automatic push(input logic [7:0] d);
        @(negedge clk_in);
        tx_data_in = d;
        tx_valid_in = 1'b1;
        do @(posedge clk_in); while (tx_ready_out !== 1'b1);
    endtask
    task automatic master_run(input int n, input bit use_crc, input bit bad_crc, input bit stop);
        logic [7:0] tx[$];
        logic [7:0] rx[$];
        int k;
        checksum_en_in = use_crc;
        for (k = 0; k < n; k++) begin
            tx.push_back(8'($urandom));
            rx.push_back(8'($urandom));
        end
        PEER.tx_q = rx;
        PEER.rx_q.delete();
        if (use_crc) begin
            PEER.tx_q.push_back(bad_crc ? ~crc8(rx) : crc8(rx));
            tx.push_back(crc8(tx));
        end
        tx_pulses = 0;
        for (k = 0; k < n && k < 8; k++) push(tx[k]);
        @(negedge clk_in);
        tx_valid_in = 1'b0;
        check(8'(tx_ready_out), 8'(n < 8));
        port_enable_in = 1'b1;
        checksum_next_ctrl_in = use_crc;
        @(negedge clk_in);
        checksum_next_ctrl_in = 1'b0;
        for (k = 8; k < n; k++) push(tx[k]);
        @(negedge clk_in);
        tx_valid_in = 1'b0;
        if (stop) begin
            while (tx_pulses == 0) @(negedge clk_in);
            port_enable_in = 1'b0;
        end
        for (k = 0; k < n; k++) begin
            for (int t = 0; t < 300 && rx_not_empty_event_out !== 1'b1; t++) @(negedge clk_in);
            check(rx_data_out, rx[k]);
            @(negedge clk_in);
        end
        for (int t = 0; t < 300 && busy_flag_out !== 1'b0; t++) @(negedge clk_in);
        port_enable_in = 1'b0;
        check(8'(busy_flag_out), 8'h00);
        check(8'(tx_pulses), 8'(n));
        check(8'(PEER.rx_q.size()), 8'(tx.size()));
        foreach (tx[i]) check(PEER.rx_q[i], tx[i]);
        check(8'(checksum_error_flag_out), 8'(bad_crc));
    endtask
    task automatic audio_run(input logic [1:0] f);
        logic [7:0] d;
        logic [7:0] first;
        do_reset();
        master_mode_in = 1'b0;
        i2s_mode_in = 1'b1;
        i2s_format_in = f;
        checksum_en_in = 1'b0;
        first = 8'($urandom);
        push(first);
        @(negedge clk_in);
        tx_valid_in = 1'b0;
        PEER.rx_q.delete();
        PEER.ws_out = (f == SSP_FMT_STD);
        port_enable_in = 1'b1;
        repeat (8) @(negedge clk_in);
        for (int k = 0; k < 3; k++) begin
            d = 8'($urandom);
            PEER.audio_word(d, (k == 1) ? (f == SSP_FMT_STD) : (f != SSP_FMT_STD));
            repeat (6) @(negedge clk_in);
            check(rx_data_out, d);
        end
        check(PEER.rx_q[0], first);
        port_enable_in = 1'b0;
    endtask
    initial begin
        void'($urandom(32'h1fab));
        do_reset();
        checksum_poly_in = 8'($urandom) | 8'h01;
        master_run(9, 1'b0, 1'b0, 1'b0);
        master_run(1, 1'b0, 1'b0, 1'b1);
        master_run(3, 1'b1, 1'b0, 1'b0);
        master_run(2, 1'b1, 1'b1, 1'b0);
        @(negedge clk_in);
        checksum_error_clr_in = 1'b1;
        @(negedge clk_in);
        checksum_error_clr_in = 1'b0;
        check(8'(checksum_error_flag_out), 8'h00);
        for (int f = 0; f < 3; f++) audio_run(2'(f));
        print_verdict();
    end
endmodule // ssp_serial_port_tb
